// File: bscan_regs.vh
// Constants of the test data register path of the boundary-scan port.
// Assumes one 25 MHz system clock that samples every test pin.
// Summary of operation
// - Selected register sits between TDI and TDO
// - Each rising TCK shifts one place toward TDO
// - Scan path never inverts bits
// - One-bit bypass register forms shortest path
// - Boundary cells are test-only logic
// - Control cell one means high-impedance or output
// - Supply, ground, test pins have no cells
// - Sample and external test capture on rising TCK
// - Serial boundary data enters on rising TCK
// - Update to pins on falling TCK
// - TDO changes on falling TCK
// - Controller moves only on rising TCK by TMS
// - Low test reset pin initialises the controller
// - Five TMS-high periods reach test-logic-reset
// - Cell 0 nearest TDO; controls 18, 25, 47
// - Five-bit instruction register, shift and latched stages
// - All-zero external test selects boundary register
// - All-one bypass selects bypass register
// - Power-on reset puts controller in test-logic-reset
`ifndef BSCAN_REGS_VH
`define BSCAN_REGS_VH

`define IR_LEN        5
`define OP_EXTEST     5'h00
`define OP_SAMPLE     5'h01
`define OP_BYPASS     5'h1f
`define IR_CAPTURE    5'h0d
`define IR_RESET      5'h1f

`define BSR_LEN       51
`define CTRL_CELL_A   18
`define CTRL_CELL_B   25
`define CTRL_CELL_C   47

`define SYNC_W        4
`define SYNC_TCK      0
`define SYNC_TMS      1
`define SYNC_TDI      2
`define SYNC_TRST     3
`define SYNC_RESET    4'h8

`endif

// File: bscan_tap.v
// Test access port controller with bypass and boundary-scan registers.
// Assumes TCK far slower than clk_sys; test pins arrive asynchronously.
`include "bscan_regs.vh"

module bscan_tap #(
  parameter BSR_LEN = `BSR_LEN
) (
  input  wire               clk_sys,
  input  wire               resetn,
  input  wire               tck,
  input  wire               tms,
  input  wire               tdi,
  input  wire               trst_n,
  output wire               tdo,
  output wire               tdo_oe,
  input  wire [BSR_LEN-1:0] bsr_capture_in,
  output wire [BSR_LEN-1:0] bsr_update_out,
  output wire               extest_mode,
  output wire [2:0]         dir_ctrl
);

  localparam [3:0] ST_TLR    = 4'h0;
  localparam [3:0] ST_RTI    = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR  = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PA_DR  = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UP_DR  = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'ha;
  localparam [3:0] ST_SH_IR  = 4'hb;
  localparam [3:0] ST_EX1_IR = 4'hc;
  localparam [3:0] ST_PA_IR  = 4'hd;
  localparam [3:0] ST_EX2_IR = 4'he;
  localparam [3:0] ST_UP_IR  = 4'hf;

  wire [`SYNC_W-1:0] pins_s;
  wire [`SYNC_W-1:0] pins_p;
  wire               tck_rise;
  wire               tck_fall;
  wire               tms_s;
  wire               tdi_s;
  wire               trst_s;

  reg  [3:0]             tap_q;
  reg  [3:0]             tap_d;
  reg  [`IR_LEN-1:0]     ir_sh_q;
  reg  [`IR_LEN-1:0]     ir_q;
  reg                    byp_q;
  reg  [BSR_LEN-1:0]     bsr_sh_q;
  reg  [BSR_LEN-1:0]     bsr_up_q;
  reg                    tdo_q;
  reg                    tdo_oe_q;
  reg                    tdo_d;

  wire sel_bsr;
  wire in_shift;
  wire tap_reset;
  wire in_tlr;
  wire cap_ir;
  wire sh_ir;
  wire up_ir;
  wire cap_dr;
  wire sh_dr;
  wire up_dr;

  pin_sync #(
    .W        (`SYNC_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({trst_n, tdi, tms, tck}),
    .sync_out (pins_s),
    .prev_out (pins_p)
  );

  // TMS and TDI pass the same stages as TCK, so they stay aligned to it
  assign tck_rise = pins_s[`SYNC_TCK] & ~pins_p[`SYNC_TCK];
  assign tck_fall = ~pins_s[`SYNC_TCK] & pins_p[`SYNC_TCK];
  assign tms_s    = pins_s[`SYNC_TMS];
  assign tdi_s    = pins_s[`SYNC_TDI];
  assign trst_s   = pins_s[`SYNC_TRST];

  // Unknown opcodes fall back to bypass
  assign sel_bsr  = (ir_q == `OP_EXTEST) | (ir_q == `OP_SAMPLE);
  assign in_shift = sh_dr | sh_ir;

  // State decodes shared by the rising and falling TCK stages
  assign in_tlr = (tap_q == ST_TLR);
  assign cap_ir = (tap_q == ST_CAP_IR);
  assign sh_ir  = (tap_q == ST_SH_IR);
  assign up_ir  = (tap_q == ST_UP_IR);
  assign cap_dr = (tap_q == ST_CAP_DR);
  assign sh_dr  = (tap_q == ST_SH_DR);
  assign up_dr  = (tap_q == ST_UP_DR);

  // Test reset acts only after the synchroniser, hence synchronously
  assign tap_reset = !resetn || !trst_s;

  always @* begin
    tap_d = tap_q;
    case (tap_q)
      ST_TLR:    tap_d = tms_s ? ST_TLR : ST_RTI;
      ST_RTI:    tap_d = tms_s ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: tap_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_d = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_d = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_d = tms_s ? ST_UP_DR : ST_PA_DR;
      ST_PA_DR:  tap_d = tms_s ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: tap_d = tms_s ? ST_UP_DR : ST_SH_DR;
      ST_UP_DR:  tap_d = tms_s ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: tap_d = tms_s ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: tap_d = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_d = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_d = tms_s ? ST_UP_IR : ST_PA_IR;
      ST_PA_IR:  tap_d = tms_s ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: tap_d = tms_s ? ST_UP_IR : ST_SH_IR;
      ST_UP_IR:  tap_d = tms_s ? ST_SEL_DR : ST_RTI;
      default:   tap_d = ST_TLR;
    endcase
  end

  // Controller state; system reset stands in for power-on reset
  always @(posedge clk_sys) begin
    if (tap_reset) begin
      tap_q <= ST_TLR;
    end else if (tck_rise) begin
      tap_q <= tap_d;
    end
  end

  // Instruction shift stage captures a fixed pattern, then shifts
  always @(posedge clk_sys) begin
    if (tap_reset) begin
      ir_sh_q <= `IR_CAPTURE;
    end else if (tck_rise && cap_ir) begin
      ir_sh_q <= `IR_CAPTURE;
    end else if (tck_rise && sh_ir) begin
      ir_sh_q <= {tdi_s, ir_sh_q[`IR_LEN-1:1]};
    end
  end

  // Bypass captures zero, which lets a chain walk count the devices
  always @(posedge clk_sys) begin
    if (tap_reset) begin
      byp_q <= 1'b0;
    end else if (tck_rise && !sel_bsr && cap_dr) begin
      byp_q <= 1'b0;
    end else if (tck_rise && !sel_bsr && sh_dr) begin
      byp_q <= tdi_s;
    end
  end

  // Boundary shift stage: parallel capture, then serial shift
  always @(posedge clk_sys) begin
    if (tap_reset) begin
      bsr_sh_q <= {BSR_LEN{1'b0}};
    end else if (tck_rise && sel_bsr && cap_dr) begin
      bsr_sh_q <= bsr_capture_in;
    end else if (tck_rise && sel_bsr && sh_dr) begin
      // TDI into MSB, cell 0 leaves first, no inversion
      bsr_sh_q <= {tdi_s, bsr_sh_q[BSR_LEN-1:1]};
    end
  end

  // Instruction switches on falling TCK, never under a shifting edge
  always @(posedge clk_sys) begin
    if (tap_reset) begin
      ir_q <= `IR_RESET;
    end else if (tck_fall && in_tlr) begin
      ir_q <= `IR_RESET;
    end else if (tck_fall && up_ir) begin
      ir_q <= ir_sh_q;
    end
  end

  // Update stage; sample preloads it, and it reaches bsr_update_out in every mode
  always @(posedge clk_sys) begin
    if (tap_reset) begin
      bsr_up_q <= {BSR_LEN{1'b0}};
    end else if (tck_fall && up_dr && sel_bsr) begin
      bsr_up_q <= bsr_sh_q;
    end
  end

  // Next serial bit; outside shift states the last bit is kept
  always @* begin
    tdo_d = tdo_q;
    if (sh_ir) begin
      tdo_d = ir_sh_q[0];
    end else if (sh_dr && sel_bsr) begin
      tdo_d = bsr_sh_q[0];
    end else if (sh_dr) begin
      tdo_d = byp_q;
    end
  end

  // Serial output and its enable change on falling TCK only
  always @(posedge clk_sys) begin
    if (tap_reset) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_q <= in_shift;
      tdo_q    <= tdo_d;
    end
  end

  assign tdo    = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // Update stage reaches bsr_update_out in every mode, sampling included; extest_mode marks external test
  assign bsr_update_out = bsr_up_q;
  assign extest_mode    = (ir_q == `OP_EXTEST);

  // A one in a control cell floats or turns round its pin group
  assign dir_ctrl = {bsr_up_q[`CTRL_CELL_C],
                     bsr_up_q[`CTRL_CELL_B],
                     bsr_up_q[`CTRL_CELL_A]};

  // Test port pins are not among the capture inputs at all

endmodule // bscan_tap

// File: bscan_tap_checker.sv
// Concurrent checks on the ports of bscan_tap.
// Assumes tck is slow against clk_sys and low while trst_n is low.
module bscan_tap_checker #(parameter BSR_LEN = 51) (
  input wire               clk_sys,
  input wire               resetn,
  input wire               tck,
  input wire               tms,
  input wire               tdi,
  input wire               trst_n,
  input wire               tdo,
  input wire               tdo_oe,
  input wire               extest_mode,
  input wire [BSR_LEN-1:0] bsr_capture_in,
  input wire [BSR_LEN-1:0] bsr_update_out,
  input wire [2:0]         dir_ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  reg       tck_q;
  reg [2:0] age_q, hi_q;
  reg [3:0] tr_q;
  // Age since a sampled tck fall; edge checks skip test reset effects
  always @(posedge clk_sys) begin
    tck_q <= tck;
    tr_q  <= {tr_q[2:0], trst_n};
    if (!resetn) begin
      age_q <= 3'h7;
      hi_q  <= 3'h0;
    end else begin
      age_q <= (tck_q && !tck) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
      if (tck && !tck_q)
        hi_q <= tms ? hi_q + {2'h0, hi_q != 3'h5} : 3'h0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence tck_fall; tck ##1 !tck; endsequence
  sequence trst_held; !trst_n [*4]; endsequence
  a_dir_map: assert property (
    dir_ctrl == {bsr_update_out[47], bsr_update_out[25], bsr_update_out[18]})
    else $error("dir_ctrl map");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |=>
    !tdo_oe && !extest_mode && bsr_update_out == '0) else $error("reset");
  a_tdo_edge: assert property (
    &tr_q && $changed(tdo) |-> age_q inside {[2:5]}) else $error("tdo edge");
  a_upd_edge: assert property (
    &tr_q && !$stable(bsr_update_out) |-> age_q inside {[2:5]})
    else $error("update edge");
  a_ir_edge: assert property (
    &tr_q && $changed(extest_mode) |-> age_q inside {[2:5]})
    else $error("ir edge");
  a_trst_init: assert property (
    trst_held |=> !tdo_oe && !extest_mode) else $error("trst");
  a_tms_five: assert property (
    hi_q == 3'h5 |-> ##12 !extest_mode && !tdo_oe) else $error("tms five");
  a_oe_hold: assert property (
    tck_fall |-> $stable(tdo_oe) [*2]) else $error("oe hold");
endmodule // bscan_tap_checker

bind bscan_tap bscan_tap_checker #(
  .BSR_LEN        (BSR_LEN)
) chk (
  .clk_sys        (clk_sys),
  .resetn         (resetn),
  .tck            (tck),
  .tms            (tms),
  .tdi            (tdi),
  .trst_n         (trst_n),
  .tdo            (tdo),
  .tdo_oe         (tdo_oe),
  .extest_mode    (extest_mode),
  .bsr_capture_in (bsr_capture_in),
  .bsr_update_out (bsr_update_out),
  .dir_ctrl       (dir_ctrl)
);

// File: jtag_master.sv
// Test master model: drives the TAP pins, samples tdo.
// Assumes clk_sys is the bench clock; tck rests low between frames.
module jtag_master (
  input  wire  clk_sys,
  input  wire  tdo,
  input  wire  tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic so;
  event got;
  initial begin
    tck = 0; tms = 1; tdi = 0; trst_n = 1;
  end
  task automatic half(); repeat (4) @(negedge clk_sys); endtask
  // tms and tdi held across the rise; tdo read just before the fall
  task automatic step(input logic s, input logic d);
    tms = s; tdi = d; half(); tck = 1; half();
    if (tdo_oe === 1'b1) begin
      so = tdo; -> got;
    end
    tck = 0;
  endtask
  task automatic pin_reset();
    trst_n = 0; repeat (2) half(); trst_n = 1; repeat (2) half();
  endtask
endmodule // jtag_master

// File: pin_sync.v
// Two-stage synchroniser for the test pins, plus one extra stage.
// Assumes asynchronous pins; the extra stage lets the caller find edges.
`include "bscan_regs.vh"

module pin_sync #(
  parameter W = `SYNC_W
) (
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out,
  output wire [W-1:0] prev_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] prev_q;

  // First stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (!resetn) begin
      meta_q <= `SYNC_RESET;
      sync_q <= `SYNC_RESET;
      prev_q <= `SYNC_RESET;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sync_out = sync_q;
  assign prev_out = prev_q;

endmodule // pin_sync

// File: tb_top.sv
// Self-checking bench for the boundary-scan data register path.
// Assumes the test master model owns the TAP pins.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 0, resetn = 0;
  logic [50:0] cap_in = 0, pat;
  logic [63:0] rnd;
  wire         tck, tms, tdi, trst_n, tdo, tdo_oe, extest_mode;
  wire  [50:0] upd;
  wire  [2:0]  dir_ctrl;
  logic        exp_q[$];
  int          mismatches = 0, total_checks = 0, seed = 98854;
  initial forever #20 clk_sys = ~clk_sys;
  bscan_tap DUT (.clk_sys(clk_sys), .resetn(resetn), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .bsr_capture_in(cap_in), .bsr_update_out(upd),
    .extest_mode(extest_mode), .dir_ctrl(dir_ctrl));
  jtag_master m (.clk_sys(clk_sys), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
    .tms(tms), .tdi(tdi), .trst_n(trst_n));
  task automatic check(input logic [50:0] g, input logic [50:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Idle to shift, n bits, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [50:0] d,
                      input logic [50:0] e);
    m.step(0, 0); m.step(1, 0);
    if (ir) m.step(1, 0);
    m.step(0, 0); m.step(0, 0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e[i]);
      m.step(i == n - 1, d[i]);
    end
    m.step(1, 0);
    m.step(0, 0);
    check({19'h0, exp_q.size()}, 51'h0);
    check({50'h0, tdo_oe}, 51'h0);
  endtask
  initial forever begin
    @(m.got);
    check({50'h0, m.so}, exp_q.size() ? {50'h0, exp_q.pop_front()} : 'x);
  end
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    resetn = 1;
    repeat (4) @(negedge clk_sys);
    rnd = {$random(seed), $random(seed)};
    pat = rnd[50:0];
    scan(0, 8, pat, {pat[6:0], 1'b0});
    scan(1, 5, 51'h0, 51'h0d);
    check({50'h0, extest_mode}, 51'h1);
    rnd = {$random(seed), $random(seed)};
    cap_in = rnd[50:0];
    rnd = {$random(seed), $random(seed)};
    pat = rnd[50:0];
    scan(0, 51, pat, cap_in);
    check(upd, pat);
    check({48'h0, dir_ctrl}, {48'h0, pat[47], pat[25], pat[18]});
    // Enter shift, then five TMS-high periods from there
    m.step(0, 0);
    m.step(1, 0);
    m.step(0, 0);
    m.step(0, 0);
    exp_q.push_back(cap_in[0]);
    repeat (5) m.step(1, 0);
    repeat (8) @(negedge clk_sys);
    check({50'h0, extest_mode}, 51'h0);
    check({50'h0, tdo_oe}, 51'h0);
    scan(1, 5, 51'h1, 51'h0d);
    check({50'h0, extest_mode}, 51'h0);
    rnd = {$random(seed), $random(seed)};
    cap_in = rnd[50:0];
    rnd = {$random(seed), $random(seed)};
    pat = rnd[50:0];
    scan(0, 51, pat, cap_in);
    check(upd, pat);
    scan(1, 5, 51'h0, 51'h0d);
    check({50'h0, extest_mode}, 51'h1);
    m.pin_reset();
    check({50'h0, extest_mode}, 51'h0);
    check(upd, 51'h0);
    complete_run();
  end
endmodule // tb_top
